// *** design/fan_mode_alarm_control.v ***
// fan_mode_alarm_control.v: mode selection, dual command port arbitration, alarm gating and indicators
// assumes two serial target engines deliver decoded one-cycle commands on clk; pins pass sync2 first
//
// Notes on behaviour
// - Each of six fan channels has its tach monitored for a fault and its own speed control output.
// - A per-channel disable written over the bus forces every alarm of that channel to read no alarm.
// - In serial mode the selected sensor's temperature stays readable but affects neither speed nor alarms.
// - In temperature mode commands from either the primary or the secondary port are accepted.
// - A speed command received in temperature mode switches at once to serial mode.
// - All alarm status stays readable while in temperature mode.
// - Simultaneous conflicting commands take the primary port and drop the secondary one.
// - Each port works alone, so an unused port may be left idle.
// - A configuration bit picks the external or on-board sensor for temperature control and alarm.
// - The normally closed relay is closed and the normally open relay open with no alarm; both flip on alarm.
// - The alarm indicator is lit while any alarm is raised and the normal indicator while none is.
// - The seven-bit target address is a fixed upper field followed by the three strap bits.
// - A low override input forces all fans to full speed; high leaves the normal mode in charge.
// - Any fan or temperature alarm drives full speed to all fans.
`timescale 1ns/1ps
`include "fan_ctrl_map.vh"
module fan_mode_alarm_control (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire [5:0] tach_fail,
  input  wire       speed_override_n,
  input  wire       addr_strap_bit0,
  input  wire       addr_strap_bit1,
  input  wire       addr_strap_bit2,
  input  wire       primary_cmd_valid,
  input  wire [1:0] primary_cmd_kind,
  input  wire [7:0] primary_cmd_data,
  input  wire       secondary_cmd_valid,
  input  wire [1:0] secondary_cmd_kind,
  input  wire [7:0] secondary_cmd_data,
  input  wire [7:0] temp_onboard,
  input  wire [7:0] temp_external,
  input  wire       onboard_sensor_open,
  input  wire       external_sensor_open,
  input  wire [7:0] temp_speed,
  input  wire       temp_over_alarm,
  output wire [6:0] target_addr,
  output reg        mode_serial,
  output reg        sensor_sel,
  output reg  [5:0] chan_disable,
  output reg  [7:0] speed_cmd,
  output reg  [5:0] fan_speed_full,
  output reg  [7:0] target_speed,
  output reg  [7:0] alarm0_status,
  output reg  [7:0] alarm1_status,
  output reg  [7:0] temp_sel,
  output reg        relay_normally_closed_pair,
  output reg        relay_normally_open_pair,
  output reg        led_alarm,
  output reg        led_normal
);
  wire [3:0] pin_s;
  wire [5:0] tach_s;
  sync2 #(.W(4)) u_sync_pins (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       ({speed_override_n, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0}),
    .rst_val (`FAN_PIN_SYNC_RST),
    .q       (pin_s)
  );
  sync2 #(.W(6)) u_sync_tach (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       (tach_fail),
    .rst_val (`FAN_TACH_SYNC_RST),
    .q       (tach_s)
  );

  // strap bits caught after reset release
  reg [2:0] strap;
  reg [1:0] strap_cnt;
  always @(posedge clk) begin
    if (sys_rst) begin
      strap     <= 3'h0;
      strap_cnt <= 2'h0;
    end else if (strap_cnt != `FAN_STRAP_CYCLES) begin
      strap_cnt <= strap_cnt + 2'h1;
      strap     <= pin_s[2:0];
    end
  end
  assign target_addr = {`FAN_ADDR_UPPER, strap};

  // arbitration: either port alone is enough, primary wins a tie
  wire       use_pri  = primary_cmd_valid;
  wire       cmd_val  = primary_cmd_valid | secondary_cmd_valid;
  wire [1:0] cmd_kind = use_pri ? primary_cmd_kind : secondary_cmd_kind;
  wire [7:0] cmd_data = use_pri ? primary_cmd_data : secondary_cmd_data;

  always @(posedge clk) begin
    if (sys_rst) begin
      mode_serial  <= `FAN_MODE_RST;
      sensor_sel   <= `FAN_SENSOR_SEL_RST;
      chan_disable <= `FAN_DIS_RST;
      speed_cmd    <= `FAN_SPEED_RST;
    end else if (cmd_val) begin
      case (cmd_kind)
        `FAN_CMD_SPEED: begin
          speed_cmd   <= cmd_data;
          mode_serial <= `FAN_MODE_SERIAL;
        end
        `FAN_CMD_CONFIG: begin
          mode_serial <= cmd_data[`FAN_CFG_MODE_BIT];
          sensor_sel  <= cmd_data[`FAN_CFG_SENSOR_BIT];
        end
        `FAN_CMD_DISABLE: begin
          chan_disable <= cmd_data[5:0];
        end
        default: begin
          speed_cmd <= speed_cmd;
        end
      endcase
    end
  end

  // alarm evaluation
  wire [5:0] fan_alarm  = tach_s & ~chan_disable;
  wire       sel_open   = (sensor_sel == `FAN_SENSOR_ONBOARD) ? onboard_sensor_open : external_sensor_open;
  wire       temp_alarm = ~mode_serial & (sel_open | temp_over_alarm);
  wire       any_alarm  = (|fan_alarm) | temp_alarm;
  wire       full_force = any_alarm | ~pin_s[3];
  wire [7:0] base_speed = mode_serial ? speed_cmd : temp_speed;
  wire [7:0] next_target = full_force ? `FAN_SPEED_FULL : base_speed;

  // status words packed for the read side
  wire [7:0] next_alarm0 = {2'b00, fan_alarm};
  wire [7:0] next_alarm1 = {temp_alarm, external_sensor_open, onboard_sensor_open, ~pin_s[3], 4'h0};
  wire [7:0] next_temp   = (sensor_sel == `FAN_SENSOR_ONBOARD) ? temp_onboard : temp_external;

  // per-channel full-speed force and target speed
  always @(posedge clk) begin
    if (sys_rst) begin
      fan_speed_full <= `FAN_FULL_RST;
      target_speed   <= `FAN_SPEED_RST;
    end else begin
      fan_speed_full <= {`FAN_NUM_CH{full_force}};
      target_speed   <= next_target;
    end
  end

  // alarm status, readable in either mode
  always @(posedge clk) begin
    if (sys_rst) begin
      alarm0_status <= `FAN_ALARM0_RST;
      alarm1_status <= `FAN_ALARM1_RST;
    end else begin
      alarm0_status <= next_alarm0;
      alarm1_status <= next_alarm1;
    end
  end

  // reading of the selected sensor, readable in either mode
  always @(posedge clk) begin
    if (sys_rst) begin
      temp_sel <= `FAN_TEMP_RST;
    end else begin
      temp_sel <= next_temp;
    end
  end

  // relay pair follows any alarm
  always @(posedge clk) begin
    if (sys_rst) begin
      relay_normally_closed_pair <= `FAN_RELAY_NC_RST;
      relay_normally_open_pair   <= `FAN_RELAY_NO_RST;
    end else begin
      relay_normally_closed_pair <= ~any_alarm;
      relay_normally_open_pair   <= any_alarm;
    end
  end

  // indicator pair follows any alarm
  always @(posedge clk) begin
    if (sys_rst) begin
      led_alarm  <= `FAN_LED_ALARM_RST;
      led_normal <= `FAN_LED_NORMAL_RST;
    end else begin
      led_alarm  <= any_alarm;
      led_normal <= ~any_alarm;
    end
  end
endmodule // fan_mode_alarm_control

// *** design/fan_ctrl_map.vh ***
// fan_ctrl_map.vh: constants for the fan mode and alarm control block
// assumes inclusion by bare name from the design files
`ifndef FAN_CTRL_MAP_VH
`define FAN_CTRL_MAP_VH
`define FAN_NUM_CH          6
`define FAN_ADDR_UPPER      4'h1
`define FAN_MODE_TEMP       1'b0
`define FAN_MODE_SERIAL     1'b1
`define FAN_MODE_RST        1'b0
`define FAN_SENSOR_EXT      1'b0
`define FAN_SENSOR_ONBOARD  1'b1
`define FAN_SENSOR_SEL_RST  1'b0
`define FAN_CMD_SPEED       2'h1
`define FAN_CMD_CONFIG      2'h2
`define FAN_CMD_DISABLE     2'h3
`define FAN_SPEED_FULL      8'h14
`define FAN_SPEED_RST       8'h14
`define FAN_DIS_RST         6'h00
`define FAN_CFG_MODE_BIT    0
`define FAN_CFG_SENSOR_BIT  1
`define FAN_STRAP_CYCLES    2'h3
`define FAN_PIN_SYNC_RST    4'hF
`define FAN_TACH_SYNC_RST   6'h00
`define FAN_FULL_RST        6'h00
`define FAN_ALARM0_RST      8'h00
`define FAN_ALARM1_RST      8'h00
`define FAN_TEMP_RST        8'hFF
`define FAN_RELAY_NC_RST    1'b1
`define FAN_RELAY_NO_RST    1'b0
`define FAN_LED_ALARM_RST   1'b0
`define FAN_LED_NORMAL_RST  1'b1
`endif

// *** design/sync2.v ***
// sync2.v: two-flop synchroniser for a bus of pin levels
// assumes the inputs are asynchronous to clk
`timescale 1ns/1ps
module sync2 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         sys_rst,
  input  wire [W-1:0] d,
  input  wire [W-1:0] rst_val,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta;
  always @(posedge clk) begin
    if (sys_rst) begin
      meta <= rst_val;
      q    <= rst_val;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // sync2

// *** tb/fan_mode_alarm_control_properties.sv ***
// fan_mode_alarm_control_properties.sv: port checks on the mode and alarm block
// assumes bind to fan_mode_alarm_control
`timescale 1ns/1ps
module fan_mode_alarm_control_properties (
  input wire logic       clk, sys_rst, speed_override_n, primary_cmd_valid, secondary_cmd_valid, mode_serial,
  input wire logic       relay_normally_closed_pair, relay_normally_open_pair, led_alarm, led_normal,
  input wire logic [1:0] primary_cmd_kind, secondary_cmd_kind,
  input wire logic [7:0] primary_cmd_data, secondary_cmd_data, speed_cmd, target_speed, alarm0_status, alarm1_status,
  input wire logic [6:0] target_addr,
  input wire logic [5:0] chan_disable, fan_speed_full
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_addr_upper: assert property (target_addr[6:3] == 4'h1) else $error("address field");
  a_primary_speed: assert property (primary_cmd_valid && primary_cmd_kind == 2'h1 |=>
    mode_serial && speed_cmd == $past(primary_cmd_data)) else $error("primary speed");
  a_second_speed: assert property (secondary_cmd_valid && secondary_cmd_kind == 2'h1 && !primary_cmd_valid |=>
    mode_serial && speed_cmd == $past(secondary_cmd_data)) else $error("secondary speed");
  a_mode_hold: assert property ($changed(mode_serial) |->
    $past(primary_cmd_valid || secondary_cmd_valid)) else $error("mode moved");
  a_disable_gate: assert property ((alarm0_status[5:0] & $past(chan_disable)) == 6'h00) else $error("gate");
  a_relay_led: assert property (relay_normally_closed_pair != relay_normally_open_pair &&
    led_alarm != led_normal && led_alarm == relay_normally_open_pair) else $error("indicators");
  a_alarm_full: assert property (led_alarm && $past(led_alarm) |-> target_speed == 8'h14) else $error("full");
  a_override_full: assert property (!speed_override_n [*4] |->
    fan_speed_full == 6'h3F && alarm1_status[4]) else $error("override");
  a_serial_temp: assert property (mode_serial && $past(mode_serial) |-> !alarm1_status[7]) else $error("temp");
  a_fixed_zero: assert property (alarm0_status[7:6] == 2'h0 && alarm1_status[3:0] == 4'h0) else $error("zero");
  c_tie: cover property (primary_cmd_valid && secondary_cmd_valid);
  c_alarm: cover property ($rose(led_alarm));
  c_back: cover property ($fell(mode_serial));
endmodule // fan_mode_alarm_control_properties
bind fan_mode_alarm_control fan_mode_alarm_control_properties i_props (.*);

// *** tb/bus_hosts.sv ***
// bus_hosts.sv: command side of both serial ports
// assumes clk is the block clock; drives on falling edges
`timescale 1ns/1ps
module bus_hosts (
  input wire logic clk,
  output logic primary_cmd_valid, secondary_cmd_valid,
  output logic [1:0] primary_cmd_kind, secondary_cmd_kind,
  output logic [7:0] primary_cmd_data, secondary_cmd_data
);
  initial {primary_cmd_valid, secondary_cmd_valid, primary_cmd_kind, secondary_cmd_kind} = '0;
  initial {primary_cmd_data, secondary_cmd_data} = '0;
  // one-cycle command on either or both ports; released payload is inverted
  task automatic send(input logic p, s, input logic [1:0] k, input logic [7:0] dp, ds);
    @(negedge clk);
    {primary_cmd_valid, primary_cmd_kind, primary_cmd_data} = {p, k, dp};
    {secondary_cmd_valid, secondary_cmd_kind, secondary_cmd_data} = {s, k, ds};
    @(negedge clk);
    {primary_cmd_valid, primary_cmd_kind, primary_cmd_data} = {1'b0, ~k, ~dp};
    {secondary_cmd_valid, secondary_cmd_kind, secondary_cmd_data} = {1'b0, ~k, ~ds};
  endtask
endmodule // bus_hosts

// *** tb/fan_mode_alarm_control_tb.sv ***
// fan_mode_alarm_control_tb.sv: command sequences with expected outputs
// assumes bus_hosts and the checker are compiled alongside
`timescale 1ns/1ps
module fan_mode_alarm_control_tb;
  logic clk = 0, sys_rst = 1, speed_override_n = 1, temp_over_alarm = 0, onboard_sensor_open = 0;
  logic external_sensor_open = 0, addr_strap_bit0 = 1, addr_strap_bit1 = 0, addr_strap_bit2 = 1;
  logic [5:0] tach_fail = '0, chan_disable, fan_speed_full;
  logic [7:0] temp_onboard = 8'h30, temp_external = 8'h40, temp_speed = 8'h0C, flags;
  logic primary_cmd_valid, secondary_cmd_valid, mode_serial, sensor_sel, led_alarm, led_normal;
  logic relay_normally_closed_pair, relay_normally_open_pair;
  logic [1:0] primary_cmd_kind, secondary_cmd_kind;
  logic [7:0] primary_cmd_data, secondary_cmd_data, speed_cmd, target_speed, alarm0_status, alarm1_status, temp_sel;
  logic [6:0] target_addr;
  int failures = 0, samples_checked = 0;
  assign flags = {mode_serial, relay_normally_closed_pair, relay_normally_open_pair, led_alarm, led_normal, 3'h0};
  fan_mode_alarm_control i_dut (.*);
  bus_hosts i_hosts (.*);
  initial forever #2.5 clk = ~clk;
  task automatic chk(input logic [7:0] seen, exp, input string nm);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  initial begin
    #100000;
    failures++;
    stop_test;
  end
  initial begin
    step(3);
    sys_rst = 0;
    step(4);
    chk(flags, 8'h48, "idle flags");
    chk({1'b0, target_addr}, 8'h0D, "addr");
    i_hosts.send(0, 1, 2'h2, 8'h00, 8'h02);
    step(1);
    chk(temp_sel, 8'h30, "onboard temp");
    i_hosts.send(1, 0, 2'h1, 8'h0A, 8'h00);
    temp_over_alarm = 1;
    step(4);
    chk(target_speed, 8'h0A, "speed");
    chk(flags, 8'hC8, "serial flags");
    temp_over_alarm = 0;
    i_hosts.send(1, 1, 2'h1, 8'h05, 8'h07);
    chk(speed_cmd, 8'h05, "tie");
    i_hosts.send(1, 0, 2'h1, 8'h03, 8'h00);
    i_hosts.send(0, 1, 2'h1, 8'h00, 8'h04);
    chk(speed_cmd, 8'h04, "order");
    i_hosts.send(1, 0, 2'h2, 8'h00, 8'h00);
    step(3);
    chk({mode_serial, temp_sel[6:0]}, 8'h40, "temp mode");
    i_hosts.send(1, 0, 2'h3, 8'h01, 8'h00);
    tach_fail = 6'h03;
    step(4);
    chk(alarm0_status, 8'h02, "gated");
    chk(flags, 8'h30, "alarm flags");
    chk(target_speed, 8'h14, "alarm speed");
    tach_fail = 6'h01;
    step(4);
    chk(flags, 8'h48, "masked flags");
    speed_override_n = 0;
    step(4);
    chk({2'h0, fan_speed_full}, 8'h3F, "override");
    chk(alarm1_status, 8'h10, "override status");
    stop_test;
  end
endmodule // fan_mode_alarm_control_tb
